// ---- rtl/ivp_ctrl.sv ----
`timescale 1ns/1ps
module ivp_ctrl
  import ivp_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              evt_ext2,
  input  wire logic              evt_ext3,
  input  wire logic              evt_ext4,
  input  wire logic              evt_ext5,
  input  wire logic              evt_ext6,
  input  wire logic              evt_ext7,
  input  wire logic              evt_tmr0_lo,
  input  wire logic              evt_tmr0_hi,
  input  wire logic              evt_ser_rx,
  input  wire logic              evt_ser_tx,
  input  wire logic              evt_adc,
  input  wire logic              evt_tbt,
  input  wire logic              evt_wpre,
  input  wire logic              evt_flash,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq,
  output logic                   cpu_req_valid,
  output logic [NUM_W-1:0]       cpu_req_num,
  output logic [LVL_W-1:0]       request_level_field,
  output logic [15:0]            cpu_vec_upper,
  output logic [15:0]            cpu_vec_lower
);
  logic [NUM_REQ-1:0]  status_r, status_nxt, enable_r, set_vec, clr_vec;
  logic [LVL_BITS-1:0] level_r;
  logic                aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0]   awaddr_r;
  logic [DATA_W-1:0]   wdata_r, rdata_r, rd_mux;
  logic [3:0]          wstrb_r;
  logic [1:0]          bresp_r, rresp_r;
  logic                vld_r;
  logic [NUM_W-1:0]    num_r;
  logic [LVL_W-1:0]    lvl_r;
  logic [15:0]         vup_r, vlo_r;
  wire                 win_valid;
  wire [NUM_W-1:0]     win_num;
  wire [LVL_W-1:0]     win_lvl;
  wire [15:0]          win_vec;

  // Merge write data into an old word under the byte strobes
  function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] o,
                                               input logic [DATA_W-1:0] d,
                                               input logic [3:0] s);
    logic [DATA_W-1:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    return r;
  endfunction

  // Source wiring onto request lines; shared lines are simply ORed,
  // so software must poll the peripheral to tell the two channels apart
  always_comb
  begin
    set_vec             = '0;
    set_vec[REQ_EXT4]   = evt_ext4;
    set_vec[REQ_EXT5]   = evt_ext5;
    set_vec[REQ_EXT26]  = evt_ext2 | evt_ext6;
    set_vec[REQ_EXT37]  = evt_ext3 | evt_ext7;
    set_vec[REQ_TMR0L]  = evt_tmr0_lo;
    set_vec[REQ_TMR0H]  = evt_tmr0_hi;
    set_vec[REQ_SER_RX] = evt_ser_rx;
    set_vec[REQ_SER_TX] = evt_ser_tx;
    set_vec[REQ_ADC]    = evt_adc;
    set_vec[REQ_TBT]    = evt_tbt;
    set_vec[REQ_WPRE]   = evt_wpre;
    set_vec[REQ_FLASH]  = evt_flash;
  end

  // Write decode from the held address and data
  wire [ADDR_W-1:0] wa     = {awaddr_r[ADDR_W-1:2], 2'b00};
  wire              do_wr  = aw_held_r && w_held_r && !bvalid_r;
  wire              hit_en = (wa == OFS_ENABLE);
  wire              hit_cl = (wa == OFS_CLEAR);
  wire              hit_l0 = (wa == OFS_LEVEL0);
  wire              hit_l1 = (wa == OFS_LEVEL1);
  wire              wr_ok  = hit_en | hit_cl | hit_l0 | hit_l1;
  wire [DATA_W-1:0] en_wd  = wmerge({8'h00, enable_r}, wdata_r, wstrb_r);
  wire [DATA_W-1:0] cl_wd  = wmerge('0, wdata_r, wstrb_r);
  wire [DATA_W-1:0] l0_wd  = wmerge(level_r[31:0], wdata_r, wstrb_r);
  wire [DATA_W-1:0] l1_wd  = wmerge({16'h0000, level_r[47:32]},
                                    wdata_r, wstrb_r);

  assign clr_vec    = (do_wr && hit_cl) ? cl_wd[NUM_REQ-1:0] : '0;
  // A new event beats a clear in the same cycle
  assign status_nxt = (status_r & ~clr_vec) | set_vec;

  // Read decode
  wire [ADDR_W-1:0] ra     = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire              rd_go  = s_axi_arvalid && !rvalid_r;
  wire              rd_ok  = (ra == OFS_STATUS) | (ra == OFS_ENABLE) |
                             (ra == OFS_CLEAR)  | (ra == OFS_LEVEL0) |
                             (ra == OFS_LEVEL1) | (ra == OFS_SELECT);
  wire [DATA_W-1:0] sel_wd = (DATA_W'(vld_r) << SEL_VLD_BIT) |
                             (DATA_W'(lvl_r) << SEL_LVL_LSB) |
                             (DATA_W'(num_r) << SEL_NUM_LSB);
  assign rd_mux = (ra == OFS_STATUS) ? {8'h00, status_r} :
                  (ra == OFS_ENABLE) ? {8'h00, enable_r} :
                  (ra == OFS_LEVEL0) ? level_r[31:0] :
                  (ra == OFS_LEVEL1) ? {16'h0000, level_r[47:32]} :
                  (ra == OFS_SELECT) ? sel_wd : '0;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // Write channel: address and data captured independently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Read channel: one-cycle answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // Status, enable and level registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_r <= RST_STATUS;
      enable_r <= RST_ENABLE;
      level_r  <= RST_LEVEL;
    end
    else
    begin
      status_r <= status_nxt;
      if (do_wr && hit_en) enable_r <= en_wd[NUM_REQ-1:0];
      if (do_wr && hit_l0) level_r[31:0] <= l0_wd;
      if (do_wr && hit_l1) level_r[47:32] <= l1_wd[15:0];
    end
  end

  // Arbitration over enabled pending requests
  ivp_select u_sel (
    .pend      (status_r & enable_r),
    .lvl       (level_r),
    .win_valid (win_valid),
    .win_num   (win_num),
    .win_lvl   (win_lvl),
    .win_vec   (win_vec)
  );

  // Registered winner for the core; lags status by one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vld_r <= 1'b0;
      num_r <= '0;
      lvl_r <= '0;
      vup_r <= VEC_TOP;
      vlo_r <= VEC_TOP + VEC_LOW_OFS;
    end
    else
    begin
      vld_r <= win_valid;
      num_r <= win_num;
      lvl_r <= win_lvl;
      vup_r <= win_vec;
      vlo_r <= win_vec + VEC_LOW_OFS;
    end
  end

  assign irq                 = |(status_r & enable_r);
  assign cpu_req_valid       = vld_r;
  assign cpu_req_num         = num_r;
  assign request_level_field = lvl_r;
  assign cpu_vec_upper       = vup_r;
  assign cpu_vec_lower       = vlo_r;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_only0;
    win_valid && win_num == 5'h00;
  endsequence
  sequence s_tie56;
    status_r[REQ_TMR0L] && enable_r[REQ_TMR0L] &&
    status_r[REQ_TMR0H] && enable_r[REQ_TMR0H] &&
    level_r[REQ_TMR0L*LVL_W +: LVL_W] == level_r[REQ_TMR0H*LVL_W +: LVL_W];
  endsequence

  a_req0_vector: assert property (s_only0 |=> cpu_vec_upper == 16'hFFFA &&
    cpu_vec_lower == 16'hFFFB) else $error("request 0 vector wrong");
  a_set_beats_clr: assert property (evt_ext4 && clr_vec[0] |=> status_r[0])
    else $error("event lost to clear");
  a_ext5_route: assert property (evt_ext5 |=> status_r[REQ_EXT5])
    else $error("channel 5 not on request 1");
  a_ext26_share: assert property (evt_ext2 || evt_ext6 |=> status_r[2])
    else $error("channels 2/6 not on request 2");
  a_ext37_share: assert property (evt_ext3 || evt_ext7 |=> status_r[3])
    else $error("channels 3/7 not on request 3");
  a_req5_vector: assert property (win_valid && win_num == 5'h05 |=>
    cpu_vec_upper == VEC_REQ5_UP && cpu_vec_lower == 16'hFFF1)
    else $error("request 5 vector wrong");
  a_tie_5_over_6: assert property (s_tie56 |-> win_num != 5'h06 ##1
    cpu_req_valid) else $error("request 6 beat request 5");
  // Only a level tie is decided by request number
  a_flash_lowest: assert property (evt_flash && !evt_ext4 ##1
    enable_r[REQ_FLASH] && enable_r[0] && status_r[0] &&
    level_r[0 +: LVL_W] == level_r[REQ_FLASH*LVL_W +: LVL_W]
    |-> win_num != 5'h17)
    else $error("flash won over request 0");
  a_irq_level: assert property ($rose(irq) |-> ##1 cpu_req_valid)
    else $error("irq without a selected request");
endmodule

// ---- rtl/ivp_pkg.sv ----
package ivp_pkg;
  // Request map and widths
  localparam int unsigned NUM_REQ  = 24;
  localparam int unsigned NUM_W    = 5;
  localparam int unsigned LVL_W    = 2;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned LVL_BITS = NUM_REQ * LVL_W;

  // Request numbers of the wired sources
  localparam int unsigned REQ_EXT4   = 0;
  localparam int unsigned REQ_EXT5   = 1;
  localparam int unsigned REQ_EXT26  = 2;
  localparam int unsigned REQ_EXT37  = 3;
  localparam int unsigned REQ_TMR0L  = 5;
  localparam int unsigned REQ_TMR0H  = 6;
  localparam int unsigned REQ_SER_RX = 7;
  localparam int unsigned REQ_SER_TX = 8;
  localparam int unsigned REQ_ADC    = 18;
  localparam int unsigned REQ_TBT    = 19;
  localparam int unsigned REQ_WPRE   = 20;
  localparam int unsigned REQ_FLASH  = 23;

  // Vector table: request n upper byte at VEC_TOP - 2n, lower byte next
  localparam logic [15:0] VEC_TOP     = 16'hFFFA;
  localparam logic [15:0] VEC_LOW_OFS = 16'h0001;
  localparam logic [15:0] VEC_REQ5_UP = 16'hFFF0;
  localparam logic [15:0] VEC_REQ6_UP = 16'hFFEE;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CLEAR  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LEVEL0 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LEVEL1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h14;

  // Select register fields
  localparam int unsigned SEL_NUM_LSB = 0;
  localparam int unsigned SEL_LVL_LSB = 8;
  localparam int unsigned SEL_VLD_BIT = 31;

  // Reset values
  localparam logic [NUM_REQ-1:0]  RST_STATUS = 24'h000000;
  localparam logic [NUM_REQ-1:0]  RST_ENABLE = 24'h000000;
  localparam logic [LVL_BITS-1:0] RST_LEVEL  = 48'hFFFF_FFFF_FFFF;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/ivp_select.sv ----
`timescale 1ns/1ps
// Picks the winning pending request: smallest level value first, and on a
// level tie the smaller request number, so precedence falls with the number.
module ivp_select
  import ivp_pkg::*;
(
  input  wire logic [NUM_REQ-1:0]  pend,
  input  wire logic [LVL_BITS-1:0] lvl,
  output logic                     win_valid,
  output logic [NUM_W-1:0]         win_num,
  output logic [LVL_W-1:0]         win_lvl,
  output logic [15:0]              win_vec
);
  logic [NUM_REQ:0]       v_c;
  logic [NUM_W-1:0]       n_c [NUM_REQ+1];
  logic [LVL_W-1:0]       l_c [NUM_REQ+1];

  assign v_c[0] = 1'b0;
  assign n_c[0] = '0;
  assign l_c[0] = '0;

  // Chain of compare stages; strict less-than keeps the earlier request
  genvar i;
  generate
    for (i = 0; i < NUM_REQ; i++)
    begin : g_stage
      wire [LVL_W-1:0] my_lvl = lvl[i*LVL_W +: LVL_W];
      wire             take   = pend[i] && (!v_c[i] || my_lvl < l_c[i]);
      assign v_c[i+1] = v_c[i] | pend[i];
      assign n_c[i+1] = take ? NUM_W'(i) : n_c[i];
      assign l_c[i+1] = take ? my_lvl : l_c[i];
    end
  endgenerate

  assign win_valid = v_c[NUM_REQ];
  assign win_num   = n_c[NUM_REQ];
  assign win_lvl   = l_c[NUM_REQ];
  assign win_vec   = VEC_TOP - {10'h000, win_num, 1'b0};
endmodule

// ---- tb/ivp_cpu_model.sv ----
`timescale 1ns/1ps
// Core side: latches the vector pair offered for the winning request
module ivp_cpu_model
  import ivp_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             cpu_req_valid,
  input  wire logic [NUM_W-1:0] cpu_req_num,
  input  wire logic [15:0]      cpu_vec_upper,
  input  wire logic [15:0]      cpu_vec_lower,
  output logic                  got_valid,
  output logic [NUM_W-1:0]      got_num,
  output logic [15:0]           got_upper,
  output logic [15:0]           got_lower
);
  // Fetch both vector bytes in the cycle the request is seen
  always_ff @(posedge aclk)
  begin
    got_valid <= aresetn & cpu_req_valid;
    if (cpu_req_valid)
    begin
      got_num   <= cpu_req_num;
      got_upper <= cpu_vec_upper;
      got_lower <= cpu_vec_lower;
    end
  end
endmodule

// ---- tb/ivp_ctrl_tb.sv ----
`timescale 1ns/1ps
module ivp_ctrl_tb;
  import ivp_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, rs;
  logic [13:0] evt = 14'h0;
  logic irq, cv, gv;
  logic [4:0] cn, gn;
  logic [1:0] cl;
  logic [15:0] cu, clo, gu, gl;
  logic [31:0] d;
  int n_mismatch = 0, checks_done = 0;
  // Source table in evt bit order, giving the request each one raises
  int req_of [14] = '{2, 3, 0, 1, 2, 3, 5, 6, 7, 8, 18, 19, 20, 23};

  ivp_ctrl ivp_ctrl_i (.aclk(aclk), .aresetn(aresetn),
    .evt_ext2(evt[0]), .evt_ext3(evt[1]), .evt_ext4(evt[2]),
    .evt_ext5(evt[3]), .evt_ext6(evt[4]), .evt_ext7(evt[5]),
    .evt_tmr0_lo(evt[6]), .evt_tmr0_hi(evt[7]), .evt_ser_rx(evt[8]),
    .evt_ser_tx(evt[9]), .evt_adc(evt[10]), .evt_tbt(evt[11]),
    .evt_wpre(evt[12]), .evt_flash(evt[13]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .cpu_req_valid(cv),
    .cpu_req_num(cn), .request_level_field(cl), .cpu_vec_upper(cu),
    .cpu_vec_lower(clo));
  ivp_cpu_model ivp_cpu_model_i (.aclk(aclk), .aresetn(aresetn),
    .cpu_req_valid(cv), .cpu_req_num(cn), .cpu_vec_upper(cu),
    .cpu_vec_lower(clo), .got_valid(gv), .got_num(gn), .got_upper(gu),
    .got_lower(gl));

  // 125 MHz machine clock
  initial
  begin
    forever #4 aclk = ~aclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      n_mismatch++;
    end
  endtask

  // A bounded wait that runs out ends the run as a failure
  task automatic tmo(input logic p);
    if (p)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // Channels are sampled mid-cycle, where the readies have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    int k;
    logic ta, tw, tb;
    logic pa, pw, pb;
    pa = 1; pw = 1; pb = 1;
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; k < 40 && pb; k++)
    begin
      @(negedge aclk);
      ta = pa & awready; tw = pw & wready; tb = bvalid; r = bresp;
      @(posedge aclk);
      if (ta) begin pa = 0; awvalid <= 0; end
      if (tw) begin pw = 0; wvalid <= 0; end
      if (tb) begin pb = 0; bready <= 0; end
    end
    // Let an edge pass so a following call does not rewrite bready
    @(posedge aclk);
    tmo(pb);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    int k;
    logic ta, pr;
    pr = 1;
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 40 && pr; k++)
    begin
      @(negedge aclk);
      ta = arvalid & arready;
      if (rvalid) begin pr = 0; v = rdata; r = rresp; end
      @(posedge aclk);
      if (ta) arvalid <= 0;
      if (!pr) rready <= 0;
    end
    // Let an edge pass so a following call does not rewrite rready
    @(posedge aclk);
    tmo(pr);
  endtask

  // Pulse sources together, check the fetched winner, then clear all
  task automatic fire(input logic [13:0] m, input int n, input logic q);
    evt <= m;
    @(posedge aclk);
    evt <= 14'h0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(gv, q);
    // A masked request never reaches the core, so no vector to check
    if (q)
    begin
      chk(gn, n[4:0]);
      chk(gu, 32'hFFFA - 2 * n);
      chk(gl, 32'hFFFB - 2 * n);
    end
    chk(irq, q);
    @(posedge aclk);
    wr(OFS_CLEAR, 32'h00FF_FFFF, rs);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(cv, 0);
    chk(irq, 0);
    @(posedge aclk);
  endtask

  task automatic t_regs();
    rd(OFS_STATUS, d, rs); chk(d, 32'h0);
    rd(OFS_ENABLE, d, rs); chk(d, 32'h0);
    rd(OFS_LEVEL0, d, rs); chk(d, 32'hFFFF_FFFF);
    rd(OFS_LEVEL1, d, rs); chk(d, 32'h0000_FFFF);
    rd(8'h40, d, rs); chk(d, 32'h0);
    chk(rs, RESP_SLVERR);
    wr(OFS_STATUS, 32'hFF, rs); chk(rs, RESP_SLVERR);
    wr(OFS_ENABLE, 32'hFFFF_FFFF, rs); chk(rs, RESP_OKAY);
    rd(OFS_ENABLE, d, rs); chk(d, 32'h00FF_FFFF);
    $display("test regs done");
  endtask

  // Every source alone must reach its request and vector pair
  task automatic t_map();
    for (int i = 0; i < 14; i++)
      fire(14'h1 << i, req_of[i], 1);
    $display("test map done");
  endtask

  task automatic t_prio();
    fire(14'h2004, 0, 1);
    fire(14'h00C0, 5, 1);
    fire(14'h0011, 2, 1);
    fire(14'h0600, 8, 1);
    fire(14'h1800, 19, 1);
    wr(OFS_LEVEL1, 32'h0000_3FFF, rs);
    fire(14'h2004, 23, 1);
    wr(OFS_LEVEL1, 32'h0000_FFFF, rs);
    $display("test prio done");
  endtask

  // Masked event stays pending without raising the line
  task automatic t_irq();
    wr(OFS_ENABLE, 32'h0, rs);
    fire(14'h0008, 1, 0);
    evt <= 14'h0008;
    @(posedge aclk);
    evt <= 14'h0;
    rd(OFS_STATUS, d, rs); chk(d, 32'h2);
    chk(irq, 0);
    wr(OFS_ENABLE, 32'h2, rs);
    @(negedge aclk);
    chk(irq, 1);
    @(posedge aclk);
    wr(OFS_CLEAR, 32'h2, rs);
    rd(OFS_STATUS, d, rs); chk(d, 32'h0);
    chk(irq, 0);
    $display("test irq done");
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_map();
    t_prio();
    t_irq();
    stop_test();
  end
endmodule
